// ===== include/lms_map.svh
// constants for the led matrix serial loader: field positions, resets, timing
`ifndef LMS_MAP_SVH
`define LMS_MAP_SVH
// ==========================================
// array geometry
`define LMS_PIXEL_BITS    160
`define LMS_ROWS          8
`define LMS_COLUMNS       20
`define LMS_CTRL_BITS     8
// ==========================================
// control byte fields
`define LMS_WORD_SEL_BIT  7
`define LMS_SLEEP_BIT     6
`define LMS_PWM_MSB       3
`define LMS_PWM_LSB       0
`define LMS_PEAK_MSB      5
`define LMS_PEAK_LSB      4
`define LMS_CHAIN_BIT     0
`define LMS_PRESCALE_BIT  1
`define LMS_WORD_RESET    7'h00
// ==========================================
// timing
`define LMS_CLK_PERIOD_NS 5
`define LMS_OSC_PERIOD_NS 5000
`define LMS_OSC_CYCLES    (`LMS_OSC_PERIOD_NS / `LMS_CLK_PERIOD_NS)
`define LMS_OSC_CNT_W     10
`define LMS_PRESCALE_DIV  8
`define LMS_ROW_SLOTS     64
`endif

// ===== include/lms_pkg.sv
// types shared by the led matrix serial loader modules
`include "lms_map.svh"
package lms_pkg;
  // ==========================================
  // types
  typedef logic [6:0] lms_word_type;                        // one 7-bit control word
  typedef logic [`LMS_PIXEL_BITS-1:0] lms_pixel_type;       // whole pixel array
  typedef enum logic [1:0] {LD_IDLE, LD_PIXEL, LD_CTRL} lms_load_type;  // shift target
endpackage

// ===== include/lms_if.sv
// interfaces between the loader, its bit buffer and its display timing module
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// valid/ready stream of shifted bits
interface lms_stream_if #(parameter int W = 2);
  logic         valid;  // word offered
  logic         ready;  // word taken
  logic [W-1:0] data;   // {path, bit}
  modport tx (output valid, output data, input ready);
  modport rx (input valid, input data, output ready);
endinterface

// ==========================================
// control words out, display timing back
interface lms_ctrl_if;
  lms_pkg::lms_word_type bright_word;  // brightness_sleep_word
  lms_pkg::lms_word_type mode_word;    // output_mode_word
  logic                  ext_osc;      // synchronised external oscillator
  logic                  use_ext;      // synchronised oscillator select
  logic                  led_on;       // pwm on-window
  logic [2:0]            row;          // row being refreshed
  logic                  osc_run;      // display oscillator running
  modport ctl (output bright_word, output mode_word, output ext_osc, output use_ext,
               input led_on, input row, input osc_run);
  modport drv (input bright_word, input mode_word, input ext_osc, input use_ext,
               output led_on, output row, output osc_run);
endinterface
`default_nettype wire

// ===== hw/lms_fifo2.sv
// two-entry valid/ready buffer for shifted bits
`timescale 1ns/10ps
`default_nettype none
module lms_fifo2 #(
  parameter int W     = 2,   // word width
  parameter int DEPTH = 2    // entries, a power of two
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  lms_stream_if.rx  s_in,
  lms_stream_if.tx  s_out
);
  import lms_pkg::*;
  localparam int AW = $clog2(DEPTH);
  // ==========================================
  // storage and pointers
  logic [W-1:0] mem [DEPTH];       // entries
  logic [AW-1:0] wr, next_wr;      // write pointer
  logic [AW-1:0] rd, next_rd;      // read pointer
  logic [AW:0]   cnt, next_cnt;    // occupancy
  logic          push, pop;        // handshakes

  assign s_in.ready  = (cnt != (AW+1)'(DEPTH));  // full refuses, source holds its word
  assign s_out.valid = (cnt != '0);
  assign s_out.data  = mem[rd];
  assign push = s_in.valid & s_in.ready;
  assign pop  = s_out.valid & s_out.ready;

  // pointer and count update
  always_comb begin
    next_wr  = push ? wr + 1'b1 : wr;
    next_rd  = pop ? rd + 1'b1 : rd;
    next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr  <= '0;
      rd  <= '0;
      cnt <= '0;
    end else begin
      wr  <= next_wr;
      rd  <= next_rd;
      cnt <= next_cnt;
    end
  end

  // data needs no reset
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr] <= s_in.data;
    end
  end
endmodule
`default_nettype wire

// ===== hw/lms_pwm.sv
// display oscillator, prescaler, row scan and pwm on-window
`timescale 1ns/10ps
`default_nettype none
`include "lms_map.svh"
module lms_pwm (
  input  wire logic i_clk,
  input  wire logic i_rst,
  lms_ctrl_if.drv   cfg
);
  import lms_pkg::*;
  // ==========================================
  // state
  logic [`LMS_OSC_CNT_W-1:0] div, next_div;  // internal oscillator divider
  logic [2:0] pre, next_pre;                 // external prescaler
  logic       prev_ext, next_prev_ext;       // for edge finding
  logic [5:0] slot, next_slot;               // oscillator cycle within a row
  logic [2:0] row, next_row;                 // row counter
  logic       led_on, next_led_on;           // on-window
  logic       awake, int_tick, ext_edge, tick, prescale;

  // on-time per pwm code, in oscillator cycles
  function automatic logic [5:0] on_time(input logic [3:0] code);
    case (code)
      4'h6:    on_time = 6'd7;
      4'h7:    on_time = 6'd9;
      4'h8:    on_time = 6'd11;
      4'h9:    on_time = 6'd14;
      4'ha:    on_time = 6'd18;
      4'hb:    on_time = 6'd22;
      4'hc:    on_time = 6'd28;
      4'hd:    on_time = 6'd36;
      4'he:    on_time = 6'd48;
      4'hf:    on_time = 6'd60;
      default: on_time = {2'b00, code};  // codes 0..5 map to themselves
    endcase
  endfunction

  assign cfg.led_on  = led_on;
  assign cfg.row     = row;
  assign cfg.osc_run = awake & ~cfg.use_ext;

  // next values; sleep freezes every counter so nothing is lost on wake
  always_comb begin
    awake         = cfg.bright_word[`LMS_SLEEP_BIT];
    prescale      = cfg.mode_word[`LMS_PRESCALE_BIT];
    int_tick      = (div == `LMS_OSC_CNT_W'(`LMS_OSC_CYCLES - 1));
    ext_edge      = cfg.ext_osc & ~prev_ext;
    next_prev_ext = cfg.ext_osc;
    // internal oscillator stops in sleep; prescale never touches it
    next_div = (awake & ~cfg.use_ext) ? (int_tick ? '0 : div + 1'b1) : div;
    next_pre = (awake & cfg.use_ext & prescale & ext_edge) ? pre + 1'b1 : pre;
    tick = awake & (cfg.use_ext ? ext_edge & (~prescale | pre == 3'(`LMS_PRESCALE_DIV - 1))
                                : int_tick);
    next_slot = tick ? slot + 1'b1 : slot;  // wraps every 64 cycles
    next_row  = (tick & slot == 6'(`LMS_ROW_SLOTS - 1)) ? row + 1'b1 : row;
    next_led_on = awake & (slot < on_time(cfg.bright_word[`LMS_PWM_MSB:`LMS_PWM_LSB]));
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div      <= '0;
      pre      <= '0;
      prev_ext <= 1'b0;
      slot     <= '0;
      row      <= '0;
      led_on   <= 1'b0;
    end else begin
      div      <= next_div;
      pre      <= next_pre;
      prev_ext <= next_prev_ext;
      slot     <= next_slot;
      row      <= next_row;
      led_on   <= next_led_on;
    end
  end
endmodule
`default_nettype wire

// ===== hw/lms_loader.sv
// serial loader of the led matrix driver: shift chains, latches, control words
//
// What this block does
// - shift serial input on rising clock while enabled
// - latched one lights pixel, zero darkens
// - enable high, clock low copies chain to latch
// - old pattern stays shown while shifting
// - copy whenever enable high and clock low; here only once the bit buffer is empty and no edge is held
// - top bit picks word; other word kept
// - old control words apply until copy
// - four-bit pwm code sets on-time table
// - two bits select peak current level
// - sleep bit zero stops oscillator, blanks
// - sleep keeps all stored data intact
// - serial mode: output is control bit seven, chain bit 0 in pixel load
// - chain mode: output follows input, control only
// - eight bits per column, column 0 leftmost
// - row zero has no pixel, never shown
// - reset zeroes control words, keeps pixel chain
// - prescale bit divides external oscillator by 8
`timescale 1ns/10ps
`default_nettype none
`include "lms_map.svh"
module lms_loader (
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic            i_register_select,
  input  wire logic            i_chip_enable_n,
  input  wire logic            i_shift_clk,
  input  wire logic            i_serial_in,
  input  wire logic            i_ext_osc,
  input  wire logic            i_use_ext_osc,
  output logic                 o_serial_out,
  output lms_pkg::lms_pixel_type o_pixel_drive,
  output logic [2:0]           o_row,
  output logic [1:0]           o_peak_current,
  output logic                 o_osc_run,
  output lms_pkg::lms_word_type o_brightness_sleep_word,
  output lms_pkg::lms_word_type o_output_mode_word
);
  import lms_pkg::*;

  // ==========================================
  // pin synchronisers
  logic [5:0] meta, sync_q;          // two stages per pin
  logic       rs, cen, sclk, sin;    // synchronised pins
  logic       prev_sclk, prev_cen;   // for edge finding
  logic       clk_rise, ce_fall;     // one-cycle events

  // all pins cross from the host domain; only the second stage is read
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta      <= '0;
      sync_q    <= 6'b00_0010;       // enable idles high
      prev_sclk <= 1'b0;
      prev_cen  <= 1'b1;
    end else begin
      meta      <= {i_use_ext_osc, i_ext_osc, i_serial_in, i_shift_clk,
                    i_chip_enable_n, i_register_select};
      sync_q    <= meta;
      prev_sclk <= sclk;
      prev_cen  <= cen;
    end
  end

  assign rs       = sync_q[0];
  assign cen      = sync_q[1];
  assign sclk     = sync_q[2];
  assign sin      = sync_q[3];
  assign clk_rise = sclk & ~prev_sclk & ~cen;
  assign ce_fall  = ~cen & prev_cen;

  // ==========================================
  // load target and held edge
  lms_load_type state, next_state;   // which chain the bits go to
  logic         pend, next_pend;     // edge waiting for buffer room
  logic         pend_bit, next_pend_bit;
  logic         hold, next_hold;     // drain pacing

  lms_stream_if #(.W(2)) s_push ();
  lms_stream_if #(.W(2)) s_pop ();

  // an edge refused by a full buffer is held, not dropped
  always_comb begin
    next_state = state;
    case (state)
      LD_IDLE, LD_PIXEL, LD_CTRL: begin
        if (ce_fall) begin
          next_state = rs ? LD_CTRL : LD_PIXEL;
        end
      end
      default: next_state = LD_IDLE;
    endcase
    s_push.valid  = clk_rise | pend;
    s_push.data   = {state == LD_CTRL, pend ? pend_bit : sin};
    next_pend     = s_push.valid & ~s_push.ready;
    next_pend_bit = pend ? pend_bit : sin;
    // the wide shift takes a word at most every other cycle, easing its enable fan-out
    next_hold     = s_pop.valid & s_pop.ready;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state    <= LD_IDLE;
      pend     <= 1'b0;
      pend_bit <= 1'b0;
      hold     <= 1'b0;
    end else begin
      state    <= next_state;
      pend     <= next_pend;
      pend_bit <= next_pend_bit;
      hold     <= next_hold;
    end
  end

  assign s_pop.ready = ~hold;

  lms_fifo2 #(.W(2), .DEPTH(2)) u_buf (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .s_in  (s_push),
    .s_out (s_pop)
  );

  // ==========================================
  // pixel shift chain and latch (never reset), control shift register
  lms_pixel_type chain, next_chain;   // pixel shift chain
  lms_pixel_type latch, next_latch;   // shown pattern
  logic [7:0]    ctrl_sr, next_ctrl_sr;
  logic          shift, copy, copy_px, copy_ct;

  assign shift = s_pop.valid & s_pop.ready;
  // copy is a level; it waits until every buffered bit has reached its chain
  assign copy    = cen & ~sclk & ~s_pop.valid & ~pend;
  assign copy_px = copy & (state == LD_PIXEL);
  assign copy_ct = copy & (state == LD_CTRL);

  always_comb begin
    next_chain   = chain;
    next_ctrl_sr = ctrl_sr;
    if (shift & ~s_pop.data[1]) begin
      next_chain = {s_pop.data[0], chain[`LMS_PIXEL_BITS-1:1]};
    end
    if (shift & s_pop.data[1]) begin
      next_ctrl_sr = {ctrl_sr[6:0], s_pop.data[0]};
    end
    // the latch only moves on a copy, so loading never disturbs the display
    next_latch = copy_px ? chain : latch;
  end

  // reset deliberately leaves pixel data alone
  always_ff @(posedge i_clk) begin
    chain   <= next_chain;
    latch   <= next_latch;
  end

  // the control shift register clears with the words, so serial out starts known
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_sr <= '0;
    end else begin
      ctrl_sr <= next_ctrl_sr;
    end
  end

  // ==========================================
  // control words
  lms_word_type bright_word, next_bright_word;
  lms_word_type mode_word, next_mode_word;

  // the unselected word keeps its value; sleep touches neither
  always_comb begin
    next_bright_word = bright_word;
    next_mode_word   = mode_word;
    if (copy_ct & ~ctrl_sr[`LMS_WORD_SEL_BIT]) begin
      next_bright_word = ctrl_sr[6:0];
    end
    if (copy_ct & ctrl_sr[`LMS_WORD_SEL_BIT]) begin
      next_mode_word = ctrl_sr[6:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bright_word <= `LMS_WORD_RESET;
      mode_word   <= `LMS_WORD_RESET;
    end else begin
      bright_word <= next_bright_word;
      mode_word   <= next_mode_word;
    end
  end

  // ==========================================
  // display timing
  lms_ctrl_if u_ctl ();
  assign u_ctl.bright_word = bright_word;
  assign u_ctl.mode_word   = mode_word;
  assign u_ctl.ext_osc     = sync_q[4];
  assign u_ctl.use_ext     = sync_q[5];

  lms_pwm u_pwm (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .cfg   (u_ctl)
  );

  // ==========================================
  // outputs
  lms_pixel_type row_mask;            // visible locations
  lms_pixel_type next_pixel_drive;
  logic          next_serial_out;

  // one generate per column: location 0 of each column has no pixel
  for (genvar c = 0; c < `LMS_COLUMNS; c++) begin : g_col
    assign row_mask[c*`LMS_ROWS +: `LMS_ROWS] = 8'hFE;
  end

  always_comb begin
    // a latched one lights during the on-window; sleep blanks everything
    next_pixel_drive = (bright_word[`LMS_SLEEP_BIT] & u_ctl.led_on) ? (latch & row_mask)
                                                                   : '0;
    if (state == LD_CTRL & ~cen & mode_word[`LMS_CHAIN_BIT]) begin
      next_serial_out = sin;
    end else if (state == LD_CTRL) begin
      next_serial_out = ctrl_sr[`LMS_CTRL_BITS-1];
    end else begin
      next_serial_out = chain[0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_serial_out            <= 1'b0;
      o_pixel_drive           <= '0;
      o_row                   <= '0;
      o_peak_current          <= '0;
      o_osc_run               <= 1'b0;
      o_brightness_sleep_word <= `LMS_WORD_RESET;
      o_output_mode_word      <= `LMS_WORD_RESET;
    end else begin
      o_serial_out            <= next_serial_out;
      o_pixel_drive           <= next_pixel_drive;
      o_row                   <= u_ctl.row;
      o_peak_current          <= bright_word[`LMS_PEAK_MSB:`LMS_PEAK_LSB];
      o_osc_run               <= u_ctl.osc_run;
      o_brightness_sleep_word <= bright_word;
      o_output_mode_word      <= mode_word;
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_reset_words: assert property (
    $past(i_rst) |-> bright_word == 7'h00 && mode_word == 7'h00)
    else $error("control words not cleared by reset");
  a_shift_pixel: assert property (
    shift & ~s_pop.data[1] |=> chain[159] == $past(s_pop.data[0]))
    else $error("pixel bit not shifted in");
  a_latch_hold: assert property (
    !copy_px |=> $stable(latch))
    else $error("latch moved without copy");
  a_latch_copy: assert property (
    copy_px |=> latch == $past(chain))
    else $error("latch did not take chain");
  a_word_select: assert property (
    copy_ct && !ctrl_sr[7] |=> bright_word == $past(ctrl_sr[6:0]) && $stable(mode_word))
    else $error("wrong control word updated");
  a_words_hold: assert property (
    !copy_ct |=> $stable(bright_word) && $stable(mode_word))
    else $error("control word changed without copy");
  a_chain_out: assert property (
    state == LD_CTRL && !cen && mode_word[0] |=> o_serial_out == $past(sin))
    else $error("chain mode output not following input");
  a_serial_out: assert property (
    state == LD_CTRL && !cen && !mode_word[0] |=> o_serial_out == $past(ctrl_sr[7]))
    else $error("serial output not control bit seven");
  a_row0_dark: assert property (
    (o_pixel_drive & ~row_mask) == '0)
    else $error("row zero driven");
  a_sleep_blank: assert property (
    !bright_word[6] ##1 !bright_word[6] |=> o_pixel_drive == '0)
    else $error("pixels driven in sleep");
  a_rs_sample: assert property (
    ce_fall |=> state == ($past(rs) ? LD_CTRL : LD_PIXEL))
    else $error("select not sampled at enable fall");

  c_pixel_copy:  cover property (copy_px ##1 $changed(latch));
  c_bright_copy: cover property (copy_ct && !ctrl_sr[7] ##1 bright_word[6]);
  c_mode_copy:   cover property (copy_ct && ctrl_sr[7]);
  c_chain_mode:  cover property (state == LD_CTRL && !cen && mode_word[0] && clk_rise);
endmodule
`default_nettype wire

// ===== verification/lms_host_model.sv
// host model that drives the serial load pins of the led matrix loader
`timescale 1ns/10ps
`default_nettype none
module lms_host_model (
  input  wire logic i_clk,
  input  wire logic i_serial_out,
  output logic      o_register_select,
  output logic      o_chip_enable_n,
  output logic      o_shift_clk,
  output logic      o_serial_in
);
  // ==========================================
  // idle pins
  // enable high, shift clock parked low: it stands still between frames
  initial begin
    o_register_select = 1'b0;
    o_chip_enable_n   = 1'b1;
    o_shift_clk       = 1'b0;
    o_serial_in       = 1'b0;
  end

  // ==========================================
  // pacing
  // every pin change lands 1 ns after a system clock edge
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // one frame of n bits of d, top bit first; so is serial out just before enable rises
  task automatic frame(input logic rs, input int n, input logic [159:0] d, output logic so);
    o_register_select = rs;       // select settles before enable falls
    wt(4);
    o_chip_enable_n = 1'b0;
    wt(4);
    o_register_select = ~rs;      // only the enable fall may count, so scramble it
    wt(8);
    // half periods of 80 ns; data settles 20 ns before each rise
    for (int k = n - 1; k >= 0; k--) begin  // top bit first, full count
      o_serial_in = d[k];
      wt(4);
      o_shift_clk = 1'b1;
      wt(16);
      o_shift_clk = 1'b0;
      wt(12);
    end
    so = i_serial_out;
    o_chip_enable_n = 1'b1;       // raised with the clock low, which starts the copy
    wt(8);
    o_serial_in = ~o_serial_in;   // a released line never shows a stale bit
    o_shift_clk = 1'b1;           // stray edge with enable high must change nothing
    wt(16);
    o_shift_clk = 1'b0;
    wt(20);
  endtask
endmodule
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the led matrix serial loader
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lms_pkg::*;
  // ==========================================
  // signals
  logic          i_clk = 1'b0;           // 200 MHz system clock
  logic          i_rst = 1'b1;           // synchronous reset
  logic          i_ext_osc = 1'b0;       // external display oscillator
  logic          i_use_ext_osc = 1'b1;   // fast external clock keeps refresh short
  logic [1:0]    oc = 2'h0;              // divider for the external oscillator
  logic          rs, ce_n, sclk, sin, sout;
  lms_pixel_type pix_drive;
  logic [2:0]    row;
  logic [1:0]    peak;
  logic          osc_run;
  lms_word_type  w0, w1;
  lms_word_type  e0 = 7'h00;             // expected brightness word
  lms_word_type  e1 = 7'h00;             // expected mode word
  logic          chain = 1'b0;           // expected chain mode
  logic [15:0]   lfsr = 16'h001D;        // fixed seed 29
  int            num_errors = 0;
  int            n_checks = 0;
  int            cnt;
  logic          so;
  lms_pixel_type la, lb, ones;
  int            tab [16] = '{0, 1, 2, 3, 4, 5, 7, 9, 11, 14, 18, 22, 28, 36, 48, 60};

  always #2.5 i_clk = ~i_clk;
  // external oscillator: one period every 8 system cycles, so one refresh is 4096 cycles
  always @(posedge i_clk) begin
    oc <= oc + 2'h1;
    if (oc == 2'h3) i_ext_osc <= #1 ~i_ext_osc;
  end

  lms_loader DUT (.i_clk(i_clk), .i_rst(i_rst), .i_register_select(rs), .i_chip_enable_n(ce_n),
    .i_shift_clk(sclk), .i_serial_in(sin), .i_ext_osc(i_ext_osc), .i_use_ext_osc(i_use_ext_osc),
    .o_serial_out(sout), .o_pixel_drive(pix_drive), .o_row(row), .o_peak_current(peak),
    .o_osc_run(osc_run), .o_brightness_sleep_word(w0), .o_output_mode_word(w1));
  lms_host_model host (.i_clk(i_clk), .i_serial_out(sout), .o_register_select(rs),
    .o_chip_enable_n(ce_n), .o_shift_clk(sclk), .o_serial_in(sin));

  // ==========================================
  // expectations
  // visible pixels: every row of a column but row 0, all driven in the on-window
  function automatic lms_pixel_type mask();
    lms_pixel_type m;
    m = '0;
    for (int c = 0; c < 20; c++) for (int r = 1; r < 8; r++) m[8*c+r] = 1'b1;
    return m;
  endfunction
  function automatic lms_pixel_type rnd();
    lms_pixel_type v;
    for (int i = 0; i < 160; i++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      v[i] = lfsr[0];
    end
    return v;
  endfunction

  // ==========================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [159:0] exp, input logic [159:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // control byte write; the copy picks one word, the other must stay
  task automatic ctrl(input logic [7:0] b);
    host.frame(1'b1, 8, {152'h0, b}, so);
    chk("serial_out", chain ? b[0] : b[7], so);
    if (b[7]) e1 = b[6:0];
    else e0 = b[6:0];
    if (b[7]) chain = b[0];
    tick(20);
    chk("word0", e0, w0);
    chk("word1", e1, w1);
    chk("peak", e0[5:4], peak);
  endtask
  // pixel frame; l is the expected latch, first bit sent lands at index 0
  task automatic pix(input lms_pixel_type l);
    lms_pixel_type d;
    d = {<<{l}};
    host.frame(1'b0, 160, d, so);
    chk("serial_out", l[0], so);
    tick(20);
  endtask
  // lit rows must match the latch; a row edge is skipped to allow one cycle of skew
  task automatic show(input lms_pixel_type l, input int n);
    logic [2:0]    p1, p2;
    lms_pixel_type pd;
    int            seen;
    p1 = 3'h0;
    p2 = 3'h1;
    pd = '0;
    seen = 0;
    repeat (n) begin
      tick(1);
      if (row === p1 && p1 === p2 && pd !== '0) begin
        seen++;
        chk("pixel_drive", l & mask(), pd);
      end
      p2 = p1;
      p1 = row;
      pd = pix_drive;
    end
    chk("rows_lit", 1'b1, seen != 0);
  endtask
  // lit cycles over one whole refresh: 8 row periods, 8 cycles per oscillator tick
  task automatic lit(input int c);
    int         rc;
    logic [2:0] pr;
    rc = 0;
    pr = row;
    cnt = 0;
    repeat (4096) begin
      tick(1);
      if (pix_drive !== '0) cnt++;
      if (row !== pr) rc++;
      pr = row;
    end
    chk("on_cycles", 64 * tab[c], cnt);
    chk("row_steps", 8, rc);
  endtask
  task automatic until_lit(input logic want, input int lim);
    int k;
    k = 0;
    while ((pix_drive !== '0) != want) begin
      tick(1);
      k++;
      if (k > lim) begin
        num_errors++;
        $display("FAIL wait_lit expected %b seen timeout", want);
        finish_test;
      end
    end
  endtask

  // ==========================================
  // main sequence
  initial begin
    tick(3);
    i_rst = 1'b0;
    tick(4);
    chk("word0", 7'h00, w0);
    chk("word1", 7'h00, w1);
    chk("pixel_drive", '0, pix_drive);
    la = rnd();
    pix(la);
    ctrl(8'h7F);  // awake, longest on-time, full current
    i_use_ext_osc = 1'b0;
    tick(8);
    chk("osc_run", 1'b1, osc_run);
    i_use_ext_osc = 1'b1;
    show(la, 4200);
    lb = rnd();
    // old pattern keeps showing while the new one shifts in
    fork
      pix(lb);
      show(la, 4096);
    join
    show(lb, 4200);
    ctrl(8'h81);  // chain mode set ahead, unused bits zero
    ones = '1;
    pix(ones);
    // pwm codes and every peak current code
    for (int c = 0; c < 16; c += 3) begin
      ctrl({2'b01, c[1:0], c[3:0]});
      lit(c);
    end
    ctrl(8'h0F);  // sleep bit low
    i_use_ext_osc = 1'b0;
    cnt = 0;
    repeat (1000) begin
      tick(1);
      if (pix_drive !== '0 || osc_run !== 1'b0) cnt++;
    end
    chk("sleep_dark", 0, cnt);
    i_use_ext_osc = 1'b1;
    ctrl(8'h7F);
    show(ones, 4200);
    ctrl(8'h82);  // serial mode, external clock divided by 8
    until_lit(1'b0, 9000);
    until_lit(1'b1, 9000);
    cnt = 0;
    while (pix_drive !== '0 && cnt < 5000) begin
      tick(1);
      cnt++;
    end
    chk("on_run", 3840, cnt);
    // reset in mid-run: words cleared, pixel data kept
    i_rst = 1'b1;
    tick(3);
    i_rst = 1'b0;
    tick(4);
    e0 = 7'h00;
    e1 = 7'h00;
    chain = 1'b0;
    chk("word0", 7'h00, w0);
    chk("word1", 7'h00, w1);
    ctrl(8'h7F);
    show(ones, 4200);
    finish_test;
  end
endmodule
`default_nettype wire
